// [issg_link.sv]
// Link-side byte catcher, clocked by the bus clock line itself.
// Assumes clr_i is raised by the system side at each start condition.
`timescale 1ns/10ps
`include "issg_map.svh"
module issg_link
   import issg_pkg::*;
(
   input  wire logic       scl_clk_i,
   input  wire logic       reset_i,
   input  wire logic       clr_i,
   input  wire logic       sda_i,
   output logic      [7:0] byte_o,
   output logic            tog_o
);
   issg_link_s s;
   issg_link_s next_s;
   logic [7:0] hold;
   logic       tog;

   always_comb begin
      next_s       = s;
      next_s.shift = {s.shift[6:0], sda_i};
      if (s.cnt == `ISSG_CNT_ACK) begin
         next_s.cnt = `ISSG_CNT_ZERO;
      end else begin
         next_s.cnt = s.cnt + 4'h1;
      end
   end

   // Slot counter restarts with every start condition
   always_ff @(posedge scl_clk_i or posedge clr_i) begin
      if (clr_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Hold stays stable for a whole byte, so a toggle is enough to cross
   always_ff @(posedge scl_clk_i or posedge reset_i) begin
      if (reset_i) begin
         hold <= `ISSG_BUF_RST;
         tog  <= 1'b0;
      end else if (s.cnt == `ISSG_CNT_LAST) begin
         hold <= next_s.shift;
         tog  <= ~tog;
      end
   end

   assign byte_o = hold;
   assign tog_o  = tog;
endmodule

// [issg_map.svh]
// Constants for the two-wire slave stretch and broadcast-call block.
// Assumes inclusion by every design file that needs offsets or counts.
`ifndef ISSG_MAP_SVH
`define ISSG_MAP_SVH

// ----------------------------------------------------------------
// Address decoding and register reset values
// ----------------------------------------------------------------
`define ISSG_GC_ADDR    8'h00
`define ISSG_RW_BIT     0
`define ISSG_SAR_RST    8'h00
`define ISSG_BUF_RST    8'h00

// ----------------------------------------------------------------
// Bit slot counts and release-bit reset
// ----------------------------------------------------------------
`define ISSG_CNT_PRE    4'hF
`define ISSG_CNT_LAST   4'h7
`define ISSG_CNT_ACK    4'h8
`define ISSG_CNT_ZERO   4'h0
`define ISSG_CKP_RST    1'b1

`endif

// [issg_master_model.sv]
// Bus master model: drives SCL and SDA in open-drain style.
// Assumes the bench resolves both wires with pull-ups and gives a tick.
`timescale 1ns/10ps
module issg_master_model (
   input  wire logic tick_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      scl_low_o,
   output logic      sda_low_o
);
   initial begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
   end

   // ----------------------------------------------------------------
   // Bit and frame primitives
   // ----------------------------------------------------------------
   // Waiting on the wire after release is how slave stretching holds us
   task automatic bit_cyc(input logic b, output logic s);
      @(posedge tick_i) sda_low_o = ~b;
      @(posedge tick_i) scl_low_o = 1'b0;
      wait (scl_i);
      @(posedge tick_i) s = sda_i;
      @(posedge tick_i) scl_low_o = 1'b1;
      @(posedge tick_i);
   endtask

   // Also serves as a repeated start from a low clock
   task automatic start;
      @(posedge tick_i) sda_low_o = 1'b0;
      @(posedge tick_i) scl_low_o = 1'b0;
      wait (scl_i);
      @(posedge tick_i) sda_low_o = 1'b1;
      @(posedge tick_i) scl_low_o = 1'b1;
      @(posedge tick_i);
   endtask

   task automatic stop;
      @(posedge tick_i) sda_low_o = 1'b1;
      @(posedge tick_i) scl_low_o = 1'b0;
      wait (scl_i);
      @(posedge tick_i) sda_low_o = 1'b0;
      repeat (2) @(posedge tick_i);
   endtask

   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cyc(d[i], s);
      end
      bit_cyc(1'b1, s);
      ack = ~s;
   endtask

   task automatic rd_byte(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cyc(1'b1, s);
         d[i] = s;
      end
      bit_cyc(~ack, s);
   endtask
endmodule

// [issg_pkg.sv]
// Types for the two-wire slave stretch and broadcast-call block.
// Assumes nothing beyond a SystemVerilog compiler.
package issg_pkg;

   // ----------------------------------------------------------------
   // Protocol phases
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ISSG_IDLE,
      ISSG_ADDR,
      ISSG_ADDR2,
      ISSG_RX,
      ISSG_TX,
      ISSG_SKIP
   } issg_state_e;

   // ----------------------------------------------------------------
   // Register sets
   // ----------------------------------------------------------------
   typedef struct packed {
      issg_state_e st;
      issg_state_e pend;
      logic [7:0]  sar;
      logic [7:0]  xbuf;
      logic        bf;
      logic        ua;
      logic        ua_hold;
      logic        clock_release_bit;
      logic        evt;
      logic        ack_pend;
      logic        rw;
      logic        da;
      logic        gc;
      logic        ten_ok;
      logic        nack;
      logic [3:0]  cnt;
      logic        scl_d;
      logic        sda_d;
      logic        tog_d;
      logic        frame_clr;
      logic        sda_oe;
      logic        scl_oe;
   } issg_main_s;

   typedef struct packed {
      logic [7:0] shift;
      logic [3:0] cnt;
   } issg_link_s;

endpackage

// [issg_slave.sv]
// Slave stretch control and broadcast-call recognition, system side.
// Assumes open-drain bus pins resolved outside; scl_clk_i is the SCL wire.
//
// What this block does
// - Ten-bit receive address phase stretches, release bit kept
// - Hold clock when update flag set at ninth
// - Update flag set after each ten-bit write address
// - Address register write ends ten-bit address stretch
// - Ten-bit data bytes stretch like seven-bit receive
// - Buffer-full stretching only in data phases
// - Early address rewrite prevents the update-flag address stretch
// - Transmit: clear release bit if buffer empty
// - Buffer loaded before ninth fall: no stretch
// - Software may set release bit any time
// - Ten-bit transmit: first two addresses use update flag
// - Third address enters transmit, buffer flag governs
// - All-zero write address is the broadcast call
// - Broadcast call only when enable bit set
// - First address byte: upper seven bits compared to own, all eight to broadcast
// - Broadcast match: buffer, full at eighth, event ninth
// - Ten-bit broadcast skips second half, no update flag
// - Seven-bit receive stretch when full at ninth
// - Release bit low drives clock line low
// - Buffer read clears the full flag
`timescale 1ns/10ps
`include "issg_map.svh"
module issg_slave
   import issg_pkg::*;
(
   input  wire logic       clock_i,
   input  wire logic       reset_i,
   input  wire logic       scl_clk_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   input  wire logic       ten_bit_mode_i,
   input  wire logic       receive_stretch_enable_i,
   input  wire logic       broadcast_call_enable_i,
   input  wire logic       clock_release_set_i,
   input  wire logic       addr_wr_i,
   input  wire logic [7:0] addr_wdata_i,
   input  wire logic       buf_wr_i,
   input  wire logic [7:0] buf_wdata_i,
   input  wire logic       buf_rd_i,
   input  wire logic       event_clr_i,
   output logic            scl_o,
   output logic            scl_oe_o,
   output logic            sda_o,
   output logic            sda_oe_o,
   output logic      [7:0] transfer_buffer_o,
   output logic      [7:0] slave_address_o,
   output logic            buffer_full_flag_o,
   output logic            address_update_flag_o,
   output logic            clock_release_bit_o,
   output logic            port_event_flag_o,
   output logic            read_write_o,
   output logic            data_not_address_o,
   output logic            general_call_o
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic hi_match(input logic [7:0] b,
                                     input logic [7:0] a);
      hi_match = (b[7:1] == a[7:1]);
   endfunction

   issg_main_s s;
   issg_main_s n;
   logic [2:0] sy;
   logic [7:0] lbyte;
   logic       ltog;
   logic       link_clr;
   logic       scl_s;
   logic       sda_s;
   logic       rise;
   logic       fall;
   logic       start;
   logic       stop;
   logic       byte_ev;
   logic       ninth;
   logic       gc_hit;
   logic       own_hit;

   // ----------------------------------------------------------------
   // Link domain and crossings
   // ----------------------------------------------------------------
   assign link_clr = reset_i | s.frame_clr;

   issg_link u_link (
      .scl_clk_i (scl_clk_i),
      .reset_i   (reset_i),
      .clr_i     (link_clr),
      .sda_i     (sda_i),
      .byte_o    (lbyte),
      .tog_o     (ltog)
   );

   issg_sync #(.WIDTH(3)) u_sync (
      .clock_i (clock_i),
      .reset_i (reset_i),
      .d_i     ({ltog, scl_i, sda_i}),
      .q_o     (sy)
   );

   assign scl_s   = sy[1];
   assign sda_s   = sy[0];
   assign rise    = scl_s & ~s.scl_d;
   assign fall    = ~scl_s & s.scl_d;
   assign start   = s.scl_d & scl_s & s.sda_d & ~sda_s;
   assign stop    = s.scl_d & scl_s & ~s.sda_d & sda_s;
   assign byte_ev = sy[2] ^ s.tog_d;
   assign ninth   = fall & (s.cnt == `ISSG_CNT_ACK);
   assign gc_hit  = broadcast_call_enable_i & (lbyte == `ISSG_GC_ADDR);
   assign own_hit = hi_match(lbyte, s.sar);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      n           = s;
      n.scl_d     = scl_s;
      n.sda_d     = sda_s;
      n.tog_d     = sy[2];
      n.frame_clr = 1'b0;

      if (fall) begin
         if (s.cnt == `ISSG_CNT_PRE || s.cnt == `ISSG_CNT_ACK) begin
            n.cnt = `ISSG_CNT_ZERO;
         end else begin
            n.cnt = s.cnt + 4'h1;
         end
         // Transmit byte fully shifted out
         if (s.st == ISSG_TX && s.cnt == `ISSG_CNT_LAST) begin
            n.bf = 1'b0;
         end
      end

      if (rise && s.st == ISSG_TX && s.cnt == `ISSG_CNT_ACK) begin
         n.nack = sda_s;
      end

      if (byte_ev) begin
         n.ack_pend = 1'b0;
         n.pend     = ISSG_SKIP;
         case (s.st)
            ISSG_ADDR: begin
               if (gc_hit && !lbyte[`ISSG_RW_BIT]) begin
                  // Broadcast skips the second address half
                  n.xbuf     = lbyte;
                  n.bf       = 1'b1;
                  n.gc       = 1'b1;
                  n.rw       = 1'b0;
                  n.ack_pend = 1'b1;
                  n.pend     = ISSG_RX;
               end else if (own_hit && !ten_bit_mode_i) begin
                  n.xbuf     = lbyte;
                  n.bf       = 1'b1;
                  n.rw       = lbyte[`ISSG_RW_BIT];
                  n.ack_pend = 1'b1;
                  n.pend     = lbyte[`ISSG_RW_BIT] ? ISSG_TX : ISSG_RX;
               end else if (own_hit && !lbyte[`ISSG_RW_BIT]) begin
                  n.ua       = 1'b1;
                  n.xbuf     = lbyte;
                  n.bf       = 1'b1;
                  n.rw       = 1'b0;
                  n.ten_ok   = 1'b0;
                  n.ack_pend = 1'b1;
                  n.pend     = ISSG_ADDR2;
               end else if (own_hit && s.ten_ok) begin
                  // Third address: read, no update flag
                  n.xbuf     = lbyte;
                  n.bf       = 1'b1;
                  n.rw       = 1'b1;
                  n.ack_pend = 1'b1;
                  n.pend     = ISSG_TX;
               end
            end
            ISSG_ADDR2: begin
               if (lbyte == s.sar) begin
                  n.ua       = 1'b1;
                  n.xbuf     = lbyte;
                  n.bf       = 1'b1;
                  n.ten_ok   = 1'b1;
                  n.ack_pend = 1'b1;
                  n.pend     = ISSG_RX;
               end else begin
                  n.ten_ok   = 1'b0;
               end
            end
            ISSG_RX: begin
               n.xbuf     = lbyte;
               n.bf       = 1'b1;
               n.da       = 1'b1;
               n.ack_pend = 1'b1;
               n.pend     = ISSG_RX;
            end
            ISSG_TX: begin
               n.pend     = ISSG_TX;
            end
            default: begin
               n.pend     = ISSG_SKIP;
            end
         endcase
      end

      if (ninth) begin
         n.ack_pend = 1'b0;
         case (s.st)
            ISSG_ADDR, ISSG_ADDR2: begin
               // Address phase: update flag only, release bit kept unless entering transmit
               n.st = s.pend;
               n.da = 1'b0;
               if (s.ack_pend) begin
                  n.evt = 1'b1;
               end
               if (s.ua) begin
                  n.ua_hold = 1'b1;
               end
               if (s.pend == ISSG_TX) begin
                  // Buffer holds the address, nothing to send yet
                  n.bf  = 1'b0;
                  n.clock_release_bit = 1'b0;
               end
            end
            ISSG_RX: begin
               n.evt = 1'b1;
               if (receive_stretch_enable_i && s.bf) begin
                  n.clock_release_bit = 1'b0;
               end
            end
            ISSG_TX: begin
               n.da = 1'b1;
               if (s.nack) begin
                  n.st = ISSG_SKIP;
               end else begin
                  n.evt = 1'b1;
                  if (!s.bf) begin
                     n.clock_release_bit = 1'b0;
                  end
               end
            end
            default: begin
               n.st = s.st;
            end
         endcase
      end

      if (start) begin
         n.st        = ISSG_ADDR;
         n.cnt       = `ISSG_CNT_PRE;
         n.frame_clr = 1'b1;
         n.ack_pend  = 1'b0;
         n.nack      = 1'b0;
         n.gc        = 1'b0;
      end else if (stop) begin
         n.st     = ISSG_IDLE;
         n.ten_ok = 1'b0;
      end

      // Software side; hardware sets win over clears, except ua_hold on an address write
      if (addr_wr_i) begin
         n.sar     = addr_wdata_i;
         n.ua_hold = 1'b0;
         if (!(byte_ev && n.ua && !s.ua)) begin
            n.ua = 1'b0;
         end
      end
      if (buf_rd_i && !(byte_ev && n.bf)) begin
         n.bf = 1'b0;
      end
      if (buf_wr_i) begin
         n.xbuf = buf_wdata_i;
         n.bf   = 1'b1;
      end
      if (event_clr_i && !(ninth && n.evt)) begin
         n.evt = 1'b0;
      end
      if (clock_release_set_i) begin
         n.clock_release_bit = 1'b1;
      end

      n.scl_oe = ~n.clock_release_bit | n.ua_hold;
      n.sda_oe = 1'b0;
      if (n.st == ISSG_TX && n.cnt <= `ISSG_CNT_LAST) begin
         n.sda_oe = ~n.xbuf[3'h7 - n.cnt[2:0]];
      end else if (n.ack_pend && n.cnt == `ISSG_CNT_ACK) begin
         n.sda_oe = 1'b1;
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         s          <= '0;
         s.st       <= ISSG_IDLE;
         s.pend     <= ISSG_IDLE;
         s.sar      <= `ISSG_SAR_RST;
         s.xbuf     <= `ISSG_BUF_RST;
         s.clock_release_bit      <= `ISSG_CKP_RST;
         s.cnt      <= `ISSG_CNT_PRE;
         // Same level as the synchroniser, so no fall is seen as it fills
         s.scl_d    <= 1'b0;
         s.sda_d    <= 1'b0;
      end else begin
         s <= n;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign scl_o                 = 1'b0;
   assign sda_o                 = 1'b0;
   assign scl_oe_o              = s.scl_oe;
   assign sda_oe_o              = s.sda_oe;
   assign transfer_buffer_o     = s.xbuf;
   assign slave_address_o       = s.sar;
   assign buffer_full_flag_o    = s.bf;
   assign address_update_flag_o = s.ua;
   assign clock_release_bit_o   = s.clock_release_bit;
   assign port_event_flag_o     = s.evt;
   assign read_write_o          = s.rw;
   assign data_not_address_o    = s.da;
   assign general_call_o        = s.gc;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (reset_i);

   property p_rx_stretch;
      (ninth && s.st == ISSG_RX && receive_stretch_enable_i && s.bf
       && !clock_release_set_i) |=> !s.clock_release_bit && s.scl_oe;
   endproperty
   a_rx_stretch: assert property (p_rx_stretch)
      else $error("receive stretch missing");

   property p_scl_low;
      !s.clock_release_bit |-> s.scl_oe;
   endproperty
   a_scl_low: assert property (p_scl_low)
      else $error("clock not held while release bit low");

   property p_buf_read;
      (buf_rd_i && !byte_ev && !buf_wr_i) |=> !s.bf;
   endproperty
   a_buf_read: assert property (p_buf_read)
      else $error("buffer read left full flag set");

   property p_tx_stretch;
      (ninth && s.st == ISSG_TX && !s.nack && !s.bf
       && !clock_release_set_i) |=> !s.clock_release_bit;
   endproperty
   a_tx_stretch: assert property (p_tx_stretch)
      else $error("transmit stretch missing");

   property p_tx_loaded;
      (ninth && s.st == ISSG_TX && s.bf && s.clock_release_bit) |=> s.clock_release_bit;
   endproperty
   a_tx_loaded: assert property (p_tx_loaded)
      else $error("stretch with buffer loaded");

   property p_addr_release;
      (addr_wr_i && s.ua_hold && !clock_release_set_i && s.clock_release_bit)
         |=> !s.ua_hold ##1 !s.scl_oe;
   endproperty
   a_addr_release: assert property (p_addr_release)
      else $error("address write did not release clock");

   property p_addr_keeps_ckp;
      (ninth && (s.st == ISSG_ADDR || s.st == ISSG_ADDR2)
       && s.pend != ISSG_TX && s.clock_release_bit) |=> s.clock_release_bit;
   endproperty
   a_addr_keeps_ckp: assert property (p_addr_keeps_ckp)
      else $error("release bit cleared in address phase");

   property p_gc_enable;
      $rose(s.gc) |-> $past(broadcast_call_enable_i);
   endproperty
   a_gc_enable: assert property (p_gc_enable)
      else $error("broadcast accepted while disabled");

   property p_gc_flags;
      (byte_ev && s.st == ISSG_ADDR && gc_hit && !start)
         |=> s.bf && s.ack_pend && !s.ua;
   endproperty
   a_gc_flags: assert property (p_gc_flags)
      else $error("broadcast match flags wrong");

   property p_ua_cause;
      $rose(s.ua) |-> $past(byte_ev && (s.st == ISSG_ADDR2
         || (s.st == ISSG_ADDR && ten_bit_mode_i)));
   endproperty
   a_ua_cause: assert property (p_ua_cause)
      else $error("update flag set outside ten-bit address");

   property p_release_set;
      clock_release_set_i |=> s.clock_release_bit;
   endproperty
   a_release_set: assert property (p_release_set)
      else $error("release bit set ignored");

   c_gc_seen: cover property ($rose(s.gc));
   c_rx_hold: cover property (ninth && s.st == ISSG_RX ##1 !s.clock_release_bit);
   c_tx_hold: cover property (ninth && s.st == ISSG_TX ##1 !s.clock_release_bit);
   c_ua_hold: cover property ($rose(s.ua_hold));
endmodule

// [issg_slave_tb_top.sv]
// Bench: slave stretch and broadcast call against a bus master model.
// Assumes design files and the master model are compiled before it.
`timescale 1ns/10ps
module issg_slave_tb_top;
   logic       clock_i, reset_i, tick, ack, m_scl, m_sda;
   logic       ten_bit_mode_i, receive_stretch_enable_i;
   logic       broadcast_call_enable_i, clock_release_set_i;
   logic       addr_wr_i, buf_wr_i, buf_rd_i, event_clr_i;
   logic [7:0] addr_wdata_i, buf_wdata_i, got;
   logic       scl_o, scl_oe_o, sda_o, sda_oe_o;
   logic [7:0] transfer_buffer_o, slave_address_o;
   logic       buffer_full_flag_o, address_update_flag_o;
   logic       clock_release_bit_o, port_event_flag_o, read_write_o;
   logic       data_not_address_o, general_call_o;
   int         n_mismatch = 0;
   int         checked = 0;
   int         cyc = 0;
   wire        scl = ~m_scl & ~(scl_oe_o & ~scl_o);
   wire        sda = ~m_sda & ~(sda_oe_o & ~sda_o);
   wire  [7:0] fl = {data_not_address_o, scl_oe_o, clock_release_bit_o,
                     address_update_flag_o, buffer_full_flag_o,
                     port_event_flag_o, read_write_o, general_call_o};
   // Rows: ten-bit, enable, address byte, ack, broadcast
   logic [11:0] rows [4] = '{12'h292, 12'h298, 12'h403, 12'h000};

   issg_slave DUT (.clock_i, .reset_i, .scl_clk_i(scl), .scl_i(scl),
      .sda_i(sda), .ten_bit_mode_i, .receive_stretch_enable_i,
      .broadcast_call_enable_i, .clock_release_set_i, .addr_wr_i,
      .addr_wdata_i, .buf_wr_i, .buf_wdata_i, .buf_rd_i, .event_clr_i,
      .scl_o, .scl_oe_o, .sda_o, .sda_oe_o, .transfer_buffer_o,
      .slave_address_o, .buffer_full_flag_o, .address_update_flag_o,
      .clock_release_bit_o, .port_event_flag_o, .read_write_o,
      .data_not_address_o, .general_call_o);
   issg_master_model m (.tick_i(tick), .scl_i(scl), .sda_i(sda),
      .scl_low_o(m_scl), .sda_low_o(m_sda));

   // ----------------------------------------------------------------
   // Clocks, timeout and helpers
   // ----------------------------------------------------------------
   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end
   // Free tick for the master, phase unrelated to the system clock
   initial begin
      tick = 1'b0;
      #7.3;
      forever #40 tick = ~tick;
   end
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish;
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] g, e, mk);
      checked++;
      if ((g & mk) !== (e & mk)) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h want %h mask %h", $time, g, e, mk);
      end
   endtask

   // Strobes: 0 release, 1 address, 2 load, 3 read, 4 event clear
   task automatic sw(input int k, input logic [7:0] d);
      @(negedge clock_i);
      addr_wdata_i = d;
      buf_wdata_i = d;
      {event_clr_i, buf_rd_i, buf_wr_i, addr_wr_i,
       clock_release_set_i} = 5'h01 << k;
      @(negedge clock_i);
      {event_clr_i, buf_rd_i, buf_wr_i, addr_wr_i,
       clock_release_set_i} = 5'h00;
      repeat (4) @(negedge clock_i);
   endtask

   task automatic settle;
      repeat (8) @(negedge clock_i);
   endtask

   task automatic wb(input logic [7:0] d);
      m.wr_byte(d, ack);
      settle();
      chk({7'h00, ack}, 8'h01, 8'h01);
   endtask

   task automatic rb(input logic a, input logic [7:0] e);
      m.rd_byte(a, got);
      settle();
      chk(got, e, 8'hFF);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      reset_i = 1'b1;
      {ten_bit_mode_i, receive_stretch_enable_i} = 2'h0;
      broadcast_call_enable_i = 1'b0;
      {event_clr_i, buf_rd_i, buf_wr_i, addr_wr_i,
       clock_release_set_i} = 5'h00;
      addr_wdata_i = 8'h00;
      buf_wdata_i = 8'h00;
      repeat (20) @(posedge clock_i);
      @(negedge clock_i) reset_i = 1'b0;
      chk(fl, 8'h20, 8'hFF);
      chk(transfer_buffer_o, 8'h00, 8'hFF);
      chk(slave_address_o, 8'h00, 8'hFF);
      sw(1, 8'hA4);
      chk(slave_address_o, 8'hA4, 8'hFF);
      foreach (rows[i]) begin
         @(negedge clock_i);
         {ten_bit_mode_i, broadcast_call_enable_i} = rows[i][11:10];
         m.start();
         m.wr_byte(rows[i][9:2], ack);
         settle();
         chk({7'h00, ack}, {7'h00, rows[i][1]}, 8'h01);
         chk(fl, {4'h2, {2{rows[i][1]}}, 1'b0, rows[i][0]},
             8'h2D);
         chk(transfer_buffer_o, rows[i][9:2], {8{rows[i][1]}});
         sw(3, 8'h00);
         sw(4, 8'h00);
         m.stop();
      end
      // Seven-bit receive: stretch on full buffer, release before read
      @(negedge clock_i) receive_stretch_enable_i = 1'b1;
      m.start();
      wb(8'hA4);
      sw(3, 8'h00);
      wb(8'h5A);
      chk(fl, 8'hC8, 8'hE8);
      chk(transfer_buffer_o, 8'h5A, 8'hFF);
      sw(0, 8'h00);
      chk(fl, 8'h28, 8'h68);
      sw(3, 8'h00);
      chk(fl, 8'h20, 8'h68);
      @(negedge clock_i) receive_stretch_enable_i = 1'b0;
      wb(8'h66);
      chk(fl, 8'hA8, 8'hE8);
      sw(3, 8'h00);
      m.stop();
      // Seven-bit transmit, then a load before the ninth fall
      m.start();
      wb(8'hA5);
      chk(fl, 8'h42, 8'h6A);
      sw(2, 8'hC3);
      sw(0, 8'h00);
      fork
         rb(1'b1, 8'hC3);
         begin
            @(negedge buffer_full_flag_o);
            sw(2, 8'h3C);
         end
      join
      chk(fl, 8'h28, 8'h68);
      rb(1'b0, 8'h3C);
      m.stop();
      // Ten-bit receive, early rewrite, then ten-bit transmit
      @(negedge clock_i);
      {ten_bit_mode_i, receive_stretch_enable_i} = 2'h3;
      sw(1, 8'hF2);
      m.start();
      wb(8'hF2);
      chk(fl, 8'h70, 8'h70);
      sw(1, 8'h34);
      chk(fl, 8'h20, 8'h70);
      fork
         wb(8'h34);
         begin
            @(posedge address_update_flag_o);
            sw(1, 8'hF2);
         end
      join
      chk(fl, 8'h28, 8'h78);
      sw(3, 8'h00);
      wb(8'h77);
      chk(fl, 8'hC8, 8'hF8);
      sw(0, 8'h00);
      sw(3, 8'h00);
      m.start();
      wb(8'hF3);
      chk(fl, 8'h42, 8'h7A);
      sw(2, 8'h9E);
      sw(0, 8'h00);
      rb(1'b1, 8'h9E);
      chk(fl, 8'h40, 8'h68);
      sw(2, 8'h5C);
      sw(0, 8'h00);
      chk(fl, 8'h28, 8'h68);
      rb(1'b0, 8'h5C);
      m.stop();
      // Ten-bit broadcast goes straight to data
      @(negedge clock_i) broadcast_call_enable_i = 1'b1;
      m.start();
      wb(8'h00);
      chk(fl, 8'h21, 8'h31);
      sw(3, 8'h00);
      wb(8'h11);
      chk(fl, 8'hC9, 8'hF9);
      chk(transfer_buffer_o, 8'h11, 8'hFF);
      sw(0, 8'h00);
      sw(3, 8'h00);
      m.stop();
      tally_and_finish();
   end
endmodule

// [issg_sync.sv]
// Two-flop synchroniser for a group of independent levels.
// Assumes each bit is a level that changes slowly against clock_i.
`timescale 1ns/10ps
module issg_sync
   import issg_pkg::*;
#(
   parameter int WIDTH = 3
) (
   input  wire logic             clock_i,
   input  wire logic             reset_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   // First stage feeds only the second stage
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } issg_sync_s;

   issg_sync_s s;
   issg_sync_s next_s;

   always_comb begin
      next_s      = s;
      next_s.meta = d_i;
      next_s.sync = s.meta;
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign q_o = s.sync;
endmodule
